// ==== hw/pwm_meter.sv ====
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module pwm_meter #(
    parameter int CNT_W = pwm_pkg::CNT_W
) (
    // clock and reset
    input  wire logic                        core_clk_in,
    input  wire logic                        resetn_in,
    input  wire logic                        ce_in,
    // pulse pin, shared with a port bit
    input  wire logic                        pulse_input_pin_in,
    // avalon-mm slave
    input  wire logic [pwm_pkg::ADDR_W-1:0]  avs_address_in,
    input  wire logic                        avs_read_in,
    input  wire logic                        avs_write_in,
    input  wire logic [pwm_pkg::DATA_W-1:0]  avs_writedata_in,
    input  wire logic [3:0]                  avs_byteenable_in,
    output logic [pwm_pkg::DATA_W-1:0]       avs_readdata_out,
    output logic                             avs_waitrequest_out,
    // interrupt
    output logic                             measure_interrupt_line_out
);
    // synchroniser
    logic                      pin_meta;
    logic                      pin_sync;
    // filter and edges
    logic                      filtered_pulse;
    logic                      filt_prev;
    logic                      rise_stb;
    logic                      fall_stb;
    logic                      sel_rise;
    logic                      sel_fall;
    logic                      sel_any;
    // timing
    logic                      cnt_tick;
    logic                      filt_tick;
    logic [CNT_W-1:0]          cnt;
    logic                      ovf;
    // registers
    logic [CNT_W-1:0]          high_width_capture;
    logic [CNT_W-1:0]          low_width_capture;
    logic                      edge_select_low;
    logic                      edge_select_high;
    logic                      overflow_irq_enable;
    logic                      edge_detect_flag;
    logic                      high_overflow_flag;
    logic                      low_overflow_flag;
    logic [pwm_pkg::SEL_W-1:0] count_sel;
    logic [pwm_pkg::SEL_W-1:0] filt_sel;
    logic [pwm_pkg::IRQ_W-1:0] irq_enable;
    // bus
    logic                      bus_req;
    logic                      wr_go;
    logic [7:0]                wdata;
    logic                      wr_ctrl1;
    logic                      wr_ctrl2;
    logic                      wr_clr;
    logic                      wr_en;
    logic                      next_irq;

    // the pin is read straight, so the port direction never hides it
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else if (ce_in) begin
            pin_meta <= pulse_input_pin_in;
            pin_sync <= pin_meta;
        end
    end

    pwm_rate_tick #(
        .BASE  (pwm_pkg::FILT_BASE),
        .DIV_W (pwm_pkg::DIV_W)
    ) u_filt_rate (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .ce_in       (ce_in),
        .sel_in      (filt_sel),
        .tick_out    (filt_tick)
    );

    pwm_rate_tick #(
        .BASE  (pwm_pkg::CNT_BASE),
        .DIV_W (pwm_pkg::DIV_W)
    ) u_cnt_rate (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .ce_in       (ce_in),
        .sel_in      (count_sel),
        .tick_out    (cnt_tick)
    );

    pwm_noise_filter #(
        .LEN (pwm_pkg::FILT_LEN)
    ) u_filter (
        .core_clk_in    (core_clk_in),
        .resetn_in      (resetn_in),
        .ce_in          (ce_in),
        .sample_tick_in (filt_tick),
        .level_in       (pin_sync),
        .level_out      (filtered_pulse)
    );

    // edge strobes, one cycle each
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            filt_prev <= 1'b0;
            rise_stb  <= 1'b0;
            fall_stb  <= 1'b0;
        end else if (ce_in) begin
            filt_prev <= filtered_pulse;
            rise_stb  <= filtered_pulse & ~filt_prev;
            fall_stb  <= ~filtered_pulse & filt_prev;
        end
    end

    // bit 0 of the select enables rises, bit 1 falls; 00 turns both off
    assign sel_rise = rise_stb & edge_select_low;
    assign sel_fall = fall_stb & edge_select_high;
    assign sel_any  = sel_rise | sel_fall;

    // an edge wins over a coincident tick: the new width starts at zero
    assign ovf = cnt_tick & (cnt == pwm_pkg::CNT_MAX) & ~sel_any;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt <= '0;
        end else if (ce_in) begin
            if (sel_any) begin
                cnt <= '0;
            end else if (cnt_tick) begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            low_width_capture  <= '0;
            high_width_capture <= '0;
        end else if (ce_in) begin
            if (sel_rise) begin
                low_width_capture <= cnt;
            end
            if (sel_fall) begin
                high_width_capture <= cnt;
            end
        end
    end

    // bus strobes; only byte lane 0 carries register bits
    assign bus_req  = avs_read_in | avs_write_in;
    assign wr_go    = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
    assign wdata    = avs_writedata_in[7:0];
    assign wr_ctrl1 = wr_go & (avs_address_in == pwm_pkg::reg_addr(pwm_pkg::IDX_CTRL1));
    assign wr_ctrl2 = wr_go & (avs_address_in == pwm_pkg::reg_addr(pwm_pkg::IDX_CTRL2));
    assign wr_clr   = wr_go & (avs_address_in == pwm_pkg::reg_addr(pwm_pkg::IDX_IRQ_CLR));
    assign wr_en    = wr_go & (avs_address_in == pwm_pkg::reg_addr(pwm_pkg::IDX_IRQ_EN));

    // fixed one wait cycle: simple to verify, costs a cycle per access
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if (ce_in) begin
            avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            avs_readdata_out <= '0;
        end else if (ce_in && avs_read_in && avs_waitrequest_out) begin
            avs_readdata_out <= '0;
            case (avs_address_in)
                pwm_pkg::reg_addr(pwm_pkg::IDX_CTRL1): begin
                    avs_readdata_out[pwm_pkg::B_EDGE_FLAG] <= edge_detect_flag;
                    avs_readdata_out[pwm_pkg::B_ESL_LOW]   <= edge_select_low;
                    avs_readdata_out[pwm_pkg::B_ESL_HIGH]  <= edge_select_high;
                    avs_readdata_out[pwm_pkg::B_LOW_OVF]   <= low_overflow_flag;
                    avs_readdata_out[pwm_pkg::B_HIGH_OVF]  <= high_overflow_flag;
                    avs_readdata_out[pwm_pkg::B_OVF_IE]    <= overflow_irq_enable;
                    avs_readdata_out[pwm_pkg::B_LEVEL]     <= filtered_pulse;
                end
                pwm_pkg::reg_addr(pwm_pkg::IDX_CTRL2): begin
                    avs_readdata_out[pwm_pkg::B_CSEL +: pwm_pkg::SEL_W] <= count_sel;
                    avs_readdata_out[pwm_pkg::B_FSEL +: pwm_pkg::SEL_W] <= filt_sel;
                end
                pwm_pkg::reg_addr(pwm_pkg::IDX_HIGH): begin
                    avs_readdata_out[CNT_W-1:0] <= high_width_capture;
                end
                pwm_pkg::reg_addr(pwm_pkg::IDX_LOW): begin
                    avs_readdata_out[CNT_W-1:0] <= low_width_capture;
                end
                pwm_pkg::reg_addr(pwm_pkg::IDX_IRQ_STAT): begin
                    avs_readdata_out[pwm_pkg::I_EDGE]     <= edge_detect_flag;
                    avs_readdata_out[pwm_pkg::I_HIGH_OVF] <= high_overflow_flag;
                    avs_readdata_out[pwm_pkg::I_LOW_OVF]  <= low_overflow_flag;
                end
                pwm_pkg::reg_addr(pwm_pkg::IDX_IRQ_EN): begin
                    avs_readdata_out[pwm_pkg::IRQ_W-1:0] <= irq_enable;
                end
                default: begin
                    avs_readdata_out <= '0;
                end
            endcase
        end
    end

    // control fields
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            edge_select_low     <= 1'b0;
            edge_select_high    <= 1'b0;
            overflow_irq_enable <= 1'b0;
            count_sel           <= '0;
            filt_sel            <= '0;
            irq_enable          <= pwm_pkg::IRQ_EN_RST;
        end else if (ce_in) begin
            if (wr_ctrl1) begin
                edge_select_low     <= wdata[pwm_pkg::B_ESL_LOW];
                edge_select_high    <= wdata[pwm_pkg::B_ESL_HIGH];
                overflow_irq_enable <= wdata[pwm_pkg::B_OVF_IE];
            end
            if (wr_ctrl2) begin
                count_sel <= wdata[pwm_pkg::B_CSEL +: pwm_pkg::SEL_W];
                filt_sel  <= wdata[pwm_pkg::B_FSEL +: pwm_pkg::SEL_W];
            end
            if (wr_en) begin
                irq_enable <= wdata[pwm_pkg::IRQ_W-1:0];
            end
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            edge_detect_flag <= 1'b0;
        end else if (ce_in) begin
            if (sel_any) begin
                edge_detect_flag <= 1'b1;
            end else if ((wr_ctrl1 && !wdata[pwm_pkg::B_EDGE_FLAG]) || (wr_clr && wdata[pwm_pkg::I_EDGE])) begin
                edge_detect_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            high_overflow_flag <= 1'b0;
        end else if (ce_in) begin
            if (ovf && filtered_pulse) begin
                high_overflow_flag <= 1'b1;
            end else if ((wr_ctrl1 && !wdata[pwm_pkg::B_HIGH_OVF]) || (wr_clr && wdata[pwm_pkg::I_HIGH_OVF])) begin
                high_overflow_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            low_overflow_flag <= 1'b0;
        end else if (ce_in) begin
            if (ovf && !filtered_pulse) begin
                low_overflow_flag <= 1'b1;
            end else if ((wr_ctrl1 && !wdata[pwm_pkg::B_LOW_OVF]) || (wr_clr && wdata[pwm_pkg::I_LOW_OVF])) begin
                low_overflow_flag <= 1'b0;
            end
        end
    end

    // edge source is silenced by select 00, overflows by the enable bit
    assign next_irq = (edge_detect_flag & irq_enable[pwm_pkg::I_EDGE]
                       & ({edge_select_high, edge_select_low} != pwm_pkg::ESL_OFF))
                    | (overflow_irq_enable & ((high_overflow_flag & irq_enable[pwm_pkg::I_HIGH_OVF])
                       | (low_overflow_flag & irq_enable[pwm_pkg::I_LOW_OVF])));

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            measure_interrupt_line_out <= 1'b0;
        end else if (ce_in) begin
            measure_interrupt_line_out <= next_irq;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    a_rise_capture_low: assert property ((ce_in && sel_rise) |=>
        low_width_capture == $past(cnt) && cnt == '0)
        else $error("rise did not load low width and clear counter");

    a_fall_capture_high: assert property ((ce_in && sel_fall) |=>
        high_width_capture == $past(cnt) && cnt == '0)
        else $error("fall did not load high width and clear counter");

    a_counter_step: assert property ((ce_in && cnt_tick && !sel_any) |=>
        cnt == CNT_W'($past(cnt) + 1'b1))
        else $error("counter did not advance on its tick");

    a_edge_flag_set: assert property ((ce_in && sel_any) |=> edge_detect_flag)
        else $error("selected edge did not set edge flag");

    a_ovf_flag_pick: assert property ((ce_in && ovf) |=>
        (filt_prev ? high_overflow_flag : low_overflow_flag))
        else $error("overflow set the wrong level flag");

    a_edge_irq_path: assert property ((ce_in && sel_any && irq_enable[pwm_pkg::I_EDGE])
        ##1 (ce_in && irq_enable[pwm_pkg::I_EDGE] && {edge_select_high, edge_select_low} != pwm_pkg::ESL_OFF)
        |=> measure_interrupt_line_out)
        else $error("selected edge did not raise interrupt");

    a_ovf_irq_gate: assert property ((!overflow_irq_enable && !edge_detect_flag) |=>
        !measure_interrupt_line_out)
        else $error("interrupt raised without an enabled source");

    a_strobe_single: assert property (rise_stb |=> !rise_stb)
        else $error("rise strobe longer than one cycle");

    a_select_off: assert property (({edge_select_high, edge_select_low} == pwm_pkg::ESL_OFF) |->
        !sel_any)
        else $error("edge taken while selection is off");

    a_bus_one_wait: assert property ((ce_in && bus_req && avs_waitrequest_out) |=>
        !avs_waitrequest_out)
        else $error("bus answer not after one wait cycle");

    c_rise_capture: cover property (ce_in && sel_rise);
    c_fall_capture: cover property (ce_in && sel_fall);
    c_overflow:     cover property (ce_in && ovf);
    c_irq_raised:   cover property ($rose(measure_interrupt_line_out));
endmodule

// ==== hw/pwm_pkg.sv ====
// Overview of operation
// - rise-rise, fall-fall, or separate high/low widths
// - measurement restarts itself after every capture
// - count clock period 2, 4, 8 or 16 tinst
// - one capture spans 1 to 2^8 count periods
// - 5-bit digital low-pass filter cleans input
// - filter sample clock 1, 2, 4 or 8 tinst
// - glitches up to five samples never pass
// - 8-bit up-counter steps once per count period
// - rise loads low width, fall high width, clear
// - one-cycle strobe on each filtered edge
// - selected edge raises the interrupt line
// - counter overflow raises interrupt when enabled
// - pin level sampled whatever the port setup
// - edge select 01 rise, 10 fall, 11 both, 00 off
// - overflow sets high or low flag; write 0 clears
// - selected edge sets edge flag; write 0 clears
package pwm_pkg;
    localparam int CNT_W   = 8;
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int SEL_W   = 2;
    localparam int IRQ_W   = 3;
    localparam int FILT_LEN  = 5;
    localparam int CNT_BASE  = 1;
    localparam int FILT_BASE = 0;
    localparam int DIV_W     = 4;

    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_CTRL1    = 8'h34;
    localparam logic [ADDR_W-1:0] IDX_CTRL2    = 8'h35;
    localparam logic [ADDR_W-1:0] IDX_HIGH     = 8'h36;
    localparam logic [ADDR_W-1:0] IDX_LOW      = 8'h37;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 8'h38;
    localparam logic [ADDR_W-1:0] IDX_IRQ_CLR  = 8'h39;
    localparam logic [ADDR_W-1:0] IDX_IRQ_EN   = 8'h3A;

    // timer_control_one fields
    localparam int B_EDGE_FLAG = 0;
    localparam int B_ESL_LOW   = 1;
    localparam int B_ESL_HIGH  = 2;
    localparam int B_LOW_OVF   = 3;
    localparam int B_HIGH_OVF  = 4;
    localparam int B_OVF_IE    = 5;
    localparam int B_LEVEL     = 6;
    // clock_select_control fields
    localparam int B_CSEL = 0;
    localparam int B_FSEL = 2;
    // interrupt status / clear / enable layout
    localparam int I_EDGE     = 0;
    localparam int I_HIGH_OVF = 1;
    localparam int I_LOW_OVF  = 2;

    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h7;
    localparam logic [CNT_W-1:0] CNT_MAX    = 8'hFF;
    localparam logic [SEL_W-1:0] ESL_OFF    = 2'h0;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [ADDR_W-1:0] idx);
        reg_addr = {idx[ADDR_W-3:0], 2'h0};
    endfunction
endpackage

// ==== hw/pwm_rate_tick.sv ====
`timescale 1ns/1ps
module pwm_rate_tick #(
    parameter int BASE  = 0,
    parameter int DIV_W = 4
) (
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    // rate select
    input  wire logic [1:0] sel_in,
    // one-cycle tick every 2^(BASE+sel) cycles
    output logic            tick_out
);
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] mask;

    // shared free-running divider, so changing sel never waits a full wrap
    assign mask = DIV_W'((1 << (BASE + int'(sel_in))) - 1);

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div <= '0;
        end else if (ce_in) begin
            div <= div + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tick_out <= 1'b0;
        end else if (ce_in) begin
            tick_out <= ((div & mask) == mask);
        end
    end
endmodule

// ==== hw/pwm_noise_filter.sv ====
`timescale 1ns/1ps
module pwm_noise_filter #(
    parameter int LEN = 5
) (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic resetn_in,
    input  wire logic ce_in,
    // sampling
    input  wire logic sample_tick_in,
    input  wire logic level_in,
    // cleaned level
    output logic      level_out
);
    localparam int RUN_W = $clog2(LEN + 1);
    localparam logic [RUN_W-1:0] RUN_MAX = RUN_W'(LEN);

    logic [RUN_W-1:0] run;

    // output follows only after LEN+1 agreeing samples
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run       <= '0;
            level_out <= 1'b0;
        end else if (ce_in && sample_tick_in) begin
            if (level_in == level_out) begin
                run <= '0;
            end else if (run == RUN_MAX) begin
                level_out <= level_in;
                run       <= '0;
            end else begin
                run <= run + 1'b1;
            end
        end
    end

    a_glitch_blocked: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        $changed(level_out) |-> $past(run) == RUN_MAX && $past(level_in) == level_out)
        else $error("filter output changed before full run");
endmodule

// ==== sim/pwm_pulse_src.sv ====
`timescale 1ns/1ps
module pwm_pulse_src (
    // clock
    input  wire logic core_clk_in,
    // pulse pin level
    output logic      pin_out
);
    // idle low between bursts; the pin has no pull, so it is always driven
    initial pin_out = 1'b0;

    // hold one level for n core cycles, changing just after an edge
    task automatic seg(input logic v, input int n);
        @(posedge core_clk_in);
        pin_out <= v;
        repeat (n - 1) @(posedge core_clk_in);
    endtask

    // k full cycles; each level must outlast the filter or it is lost
    task automatic pulse(input int hi, input int lo, input int k);
        repeat (k) begin
            seg(1'b1, hi);
            seg(1'b0, lo);
        end
    endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] A_C1 = 8'hD0;
    localparam logic [7:0] A_C2 = 8'hD4;
    localparam logic [7:0] A_HI = 8'hD8;
    localparam logic [7:0] A_LO = 8'hDC;
    localparam logic [7:0] A_ST = 8'hE0;
    localparam logic [7:0] A_CL = 8'hE4;
    localparam logic [7:0] A_EN = 8'hE8;

    logic        core_clk;
    logic        resetn;
    logic        pin;
    logic [7:0]  addr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  be;
    logic        wait_req;
    logic        irq;
    logic [31:0] q;
    int          n_errors;
    int          n_compared;

    always #25 core_clk = ~core_clk;

    pwm_pulse_src pwm_pulse_src_i (.core_clk_in(core_clk), .pin_out(pin));

    pwm_meter pwm_meter_i (
        .core_clk_in               (core_clk),
        .resetn_in                 (resetn),
        .ce_in                     (1'b1),
        .pulse_input_pin_in        (pin),
        .avs_address_in            (addr),
        .avs_read_in               (rd_en),
        .avs_write_in              (wr_en),
        .avs_writedata_in          (wdata),
        .avs_byteenable_in         (be),
        .avs_readdata_out          (rdata),
        .avs_waitrequest_out       (wait_req),
        .measure_interrupt_line_out(irq)
    );

    // tolerance covers the free-running count tick phase
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input int tol = 0);
        n_compared++;
        if ($isunknown(seen) || (seen > exp + tol) || (seen + tol < exp)) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge core_clk);
        rd_en <= ~w;
        wr_en <= w;
        addr  <= a;
        wdata <= d;
        be    <= b;
        do begin
            @(posedge core_clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_errors++;
        end
        q = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask

    // interrupt is registered one edge behind its flags
    task automatic irq_is(input logic e);
        repeat (2) @(posedge core_clk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic results;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        results();
    end

    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        be = 4'hF;
        n_errors = 0;
        n_compared = 0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        rd(A_C1);
        chk(q, 32'h0);
        rd(A_C2);
        chk(q, 32'h0);
        rd(A_HI);
        chk(q, 32'h0);
        rd(A_EN);
        chk(q, 32'h7);
        rd(8'hF0);
        chk(q, 32'h0);
        irq_is(1'b0);
        // read-only capture and disabled byte lanes keep old contents
        wr(A_HI, 32'h55);
        rd(A_HI);
        chk(q, 32'h0);
        bus(1'b1, A_C2, 32'h0F, 4'h0);
        rd(A_C2);
        chk(q, 32'h0);
        // both edges: separate high and low widths
        wr(A_C1, 32'h06);
        pwm_pulse_src_i.pulse(100, 60, 3);
        rd(A_HI);
        chk(q, 32'd50, 1);
        rd(A_LO);
        chk(q, 32'd30, 1);
        rd(A_ST);
        chk(q & 32'h1, 32'h1);
        irq_is(1'b1);
        wr(A_C1, 32'h07);
        rd(A_C1);
        chk(q & 32'h1, 32'h1);
        wr(A_C1, 32'h06);
        rd(A_C1);
        chk(q & 32'h1, 32'h0);
        irq_is(1'b0);
        // falling only: full cycle into the high register
        wr(A_C1, 32'h04);
        pwm_pulse_src_i.pulse(100, 60, 3);
        rd(A_HI);
        chk(q, 32'd80, 1);
        wr(A_CL, 32'h1);
        rd(A_ST);
        chk(q & 32'h1, 32'h0);
        // edge select off: no flag, no interrupt
        wr(A_C1, 32'h00);
        pwm_pulse_src_i.pulse(100, 60, 2);
        rd(A_C1);
        chk(q & 32'h1, 32'h0);
        irq_is(1'b0);
        // rising only, every count clock rate, measurement self-restarting
        for (int c = 0; c < 4; c++) begin
            wr(A_C2, c);
            wr(A_C1, 32'h02);
            pwm_pulse_src_i.pulse(100, 60, 3);
            rd(A_LO);
            chk(q, 32'd160 >> (c + 1), 1);
        end
        // every filter rate: five samples are dropped, seven pass and set the flag
        for (int f = 0; f < 4; f++) begin
            wr(A_C2, f << 2);
            wr(A_C1, 32'h06);
            pwm_pulse_src_i.seg(1'b1, 5 << f);
            pwm_pulse_src_i.seg(1'b0, 60);
            rd(A_C1);
            chk(q & 32'h41, 32'h0);
            pwm_pulse_src_i.seg(1'b1, 7 << f);
            pwm_pulse_src_i.seg(1'b0, 60);
            rd(A_C1);
            chk(q & 32'h41, 32'h1);
        end
        pwm_pulse_src_i.seg(1'b1, 100);
        rd(A_C1);
        chk(q & 32'h41, 32'h41);
        pwm_pulse_src_i.seg(1'b0, 100);
        // overflow while low, then masking and clearing
        wr(A_C2, 32'h00);
        wr(A_C1, 32'h20);
        pwm_pulse_src_i.seg(1'b0, 600);
        rd(A_C1);
        chk(q & 32'h18, 32'h08);
        irq_is(1'b1);
        wr(A_EN, 32'h3);
        irq_is(1'b0);
        wr(A_EN, 32'h7);
        irq_is(1'b1);
        wr(A_CL, 32'h4);
        rd(A_ST);
        chk(q & 32'h6, 32'h0);
        irq_is(1'b0);
        // overflow while high; writing one leaves the flag set
        pwm_pulse_src_i.seg(1'b1, 20);
        wr(A_C1, 32'h20);
        pwm_pulse_src_i.seg(1'b1, 600);
        wr(A_C1, 32'h38);
        rd(A_C1);
        chk(q & 32'h18, 32'h10);
        wr(A_C1, 32'h20);
        rd(A_C1);
        chk(q & 32'h18, 32'h00);
        irq_is(1'b0);
        results();
    end
endmodule
